// [hw/nvsc_host_ctrl.sv]
// Operation
// - Write strobe stays high through every read access of the array.
// - Command sequence uses chip-select-controlled reads, one select per access.
// - Six consecutive reads in exact order, write strobe high throughout.
// - Each sequence read lasts at least 25 ns or 45 ns per grade.
// - Order 0E38,31C7,03E0,3C1F,303F then 0FC0 store or 0C63 recall.
// - Write when select and strobe low; address stable whole write.
`timescale 1ns/1ps
module nvsc_host_ctrl
    import nvsc_pkg::*;
#(
    parameter int unsigned PWRUP_WAIT_CYC = nvsc_pkg::PWRUP_CYC,
    parameter int unsigned STORE_WAIT_CYC = nvsc_pkg::STORE_CYC_IND
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Supply monitor
    input wire logic vcc_ok,
    // User command port
    input wire logic cmd_valid,
    input wire nvsc_pkg::nvsc_op_t cmd_op,
    input wire logic [nvsc_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [nvsc_pkg::DATA_W-1:0] cmd_wdata,
    output logic cmd_ready,
    // User response port
    output logic rsp_valid,
    output logic [nvsc_pkg::DATA_W-1:0] rsp_rdata,
    output logic busy,
    // Memory pins
    output logic mem_ce_n,
    output logic mem_we_n,
    output logic mem_oe_n,
    output logic [nvsc_pkg::ADDR_W-1:0] mem_addr,
    output logic [nvsc_pkg::DATA_W-1:0] mem_dq_out,
    output logic mem_dq_oe,
    input wire logic [nvsc_pkg::DATA_W-1:0] mem_dq_in
);
    import nvsc_pkg::*;

    // ------------------------------------------------------------
    // Sequence address lookup
    // ------------------------------------------------------------
    function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] idx, input logic recall);
        logic [ADDR_W-1:0] a;
        a = SEQ_ADDR0;
        case (idx)
            3'h0: a = SEQ_ADDR0;
            3'h1: a = SEQ_ADDR1;
            3'h2: a = SEQ_ADDR2;
            3'h3: a = SEQ_ADDR3;
            3'h4: a = SEQ_ADDR4;
            3'h5: a = recall ? SEQ_RECALL : SEQ_STORE;
            default: a = SEQ_ADDR0;
        endcase
        return a;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    nvsc_state_t state_r;
    nvsc_state_t state_nxt;
    nvsc_op_t op_r;
    logic [2:0] seq_idx_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] wdata_r;
    logic user_nv_r;
    logic cmd_ready_r;
    logic rsp_valid_r;
    logic [DATA_W-1:0] rdata_r;
    logic busy_r;
    logic ce_n_r;
    logic we_n_r;
    logic oe_n_r;
    logic [ADDR_W-1:0] pin_addr_r;
    logic [DATA_W-1:0] dq_out_r;
    logic dq_oe_r;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic accept;
    logic is_seq;
    logic is_write;
    logic is_read;
    logic seq_last;
    logic tmr_expired;
    logic tmr_start;
    logic [TMR_W-1:0] tmr_load;
    logic strobe_done;
    logic nv_done;
    logic [ADDR_W-1:0] pin_addr_nxt;
    logic ce_n_nxt;
    logic we_n_nxt;
    logic oe_n_nxt;
    logic dq_oe_nxt;
    logic rsp_nxt;
    logic [TMR_W-1:0] strobe_load;
    logic [TMR_W-1:0] pwrup_load;
    logic [TMR_W-1:0] nv_load;

    // Commands only taken in idle with supply good
    assign accept = (state_r == ST_IDLE) && cmd_valid && cmd_ready_r && vcc_ok;
    assign is_seq = (op_r == OP_STORE) || (op_r == OP_RECALL);
    assign is_write = (op_r == OP_WRITE);
    assign is_read = (op_r == OP_READ);
    assign seq_last = (seq_idx_r == 3'(SEQ_LEN - 1));
    assign strobe_done = (state_r == ST_STROBE) && tmr_expired;
    assign nv_done = (state_r == ST_NVWAIT) && tmr_expired;

    // Timer loads: N-1 gives N cycles
    assign strobe_load = TMR_W'(STROBE_CYC - 1);
    assign pwrup_load = TMR_W'(PWRUP_WAIT_CYC - 1);
    assign nv_load = (op_r == OP_RECALL) ? TMR_W'(RECALL_CYC - 1) : TMR_W'(STORE_WAIT_CYC - 1);

    // Strobe length covers cycle time of both grades
    assign tmr_start = (state_r == ST_SETUP)
                    || ((state_r == ST_OFF) && vcc_ok)
                    || ((state_r == ST_HOLD) && is_seq && seq_last);
    // Power-up wait from supply crossing; nonvolatile wait after last read
    assign tmr_load = (state_r == ST_SETUP) ? strobe_load :
                      (state_r == ST_OFF) ? pwrup_load : nv_load;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Low supply drops everything: device ignores accesses meanwhile
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_OFF: begin
                if (vcc_ok) begin
                    state_nxt = ST_NVWAIT;
                end
            end
            ST_IDLE: begin
                if (accept) begin
                    state_nxt = ST_SETUP;
                end
            end
            ST_SETUP: state_nxt = ST_STROBE;
            ST_STROBE: begin
                if (tmr_expired) begin
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // Sequence reads follow back to back, nothing in between
                if (is_seq && !seq_last) begin
                    state_nxt = ST_SETUP;
                end else if (is_seq) begin
                    state_nxt = ST_NVWAIT;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_NVWAIT: begin
                // No access may start until the device is done
                if (tmr_expired) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_OFF;
        endcase
        if (!vcc_ok) begin
            state_nxt = ST_OFF;
        end
    end

    // ------------------------------------------------------------
    // Pin next values
    // ------------------------------------------------------------
    // Sequence address carries only 13 meaningful bits; bit 13 is set in 31C7, 3C1F and 303F
    assign pin_addr_nxt = (state_nxt == ST_SETUP) ?
                          (accept ? cmd_addr : (is_seq ? seq_addr(seq_idx_r + 3'h1, op_r == OP_RECALL) : addr_r))
                          : pin_addr_r;
    // One select pulse per access
    assign ce_n_nxt = (state_nxt != ST_STROBE);
    // Strobe low from setup: select falls with strobe low, outputs stay off
    assign we_n_nxt = !(((state_nxt == ST_SETUP) && (accept ? (cmd_op == OP_WRITE) : is_write))
                     || ((state_nxt == ST_STROBE) && is_write));
    // Gate only on array reads; sequence reads leave the bus alone
    assign oe_n_nxt = !((state_nxt == ST_STROBE) && is_read);
    assign dq_oe_nxt = !we_n_nxt;
    assign rsp_nxt = ((state_r == ST_HOLD) && !is_seq) || (nv_done && user_nv_r);

    // ------------------------------------------------------------
    // Command capture
    // ------------------------------------------------------------
    // Sequence starts at its first address
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            op_r <= OP_READ;
            addr_r <= ADDR_RST;
            wdata_r <= DATA_RST;
            seq_idx_r <= 3'h0;
            user_nv_r <= 1'b0;
        end else begin
            if (accept) begin
                op_r <= cmd_op;
                addr_r <= ((cmd_op == OP_STORE) || (cmd_op == OP_RECALL)) ? SEQ_ADDR0 : cmd_addr;
                wdata_r <= cmd_wdata;
                seq_idx_r <= 3'h0;
                user_nv_r <= (cmd_op == OP_STORE) || (cmd_op == OP_RECALL);
            end else if ((state_r == ST_HOLD) && is_seq && !seq_last) begin
                seq_idx_r <= seq_idx_r + 3'h1;
            end
            if (state_r == ST_OFF) begin
                user_nv_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Control and pins
    // ------------------------------------------------------------
    // Pins registered so the memory sees clean edges
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_OFF;
            ce_n_r <= 1'b1;
            we_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            pin_addr_r <= ADDR_RST;
            dq_out_r <= DATA_RST;
            dq_oe_r <= 1'b0;
            cmd_ready_r <= 1'b0;
            rsp_valid_r <= 1'b0;
            busy_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            ce_n_r <= ce_n_nxt;
            we_n_r <= we_n_nxt;
            oe_n_r <= oe_n_nxt;
            pin_addr_r <= (accept && ((cmd_op == OP_STORE) || (cmd_op == OP_RECALL))) ? SEQ_ADDR0 : pin_addr_nxt;
            dq_out_r <= accept ? cmd_wdata : wdata_r;
            dq_oe_r <= dq_oe_nxt;
            cmd_ready_r <= (state_nxt == ST_IDLE);
            rsp_valid_r <= rsp_nxt;
            busy_r <= (state_nxt != ST_IDLE);
        end
    end

    // Read data taken on the last strobe cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= DATA_RST;
        end else if (strobe_done && is_read) begin
            rdata_r <= mem_dq_in;
        end
    end

    // ------------------------------------------------------------
    // Shared wait timer
    // ------------------------------------------------------------
    nvsc_wait_timer #(
        .W(TMR_W)
    ) u_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(tmr_start),
        .load(tmr_load),
        .expired(tmr_expired)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign cmd_ready = cmd_ready_r;
    assign rsp_valid = rsp_valid_r;
    assign rsp_rdata = rdata_r;
    assign busy = busy_r;
    assign mem_ce_n = ce_n_r;
    assign mem_we_n = we_n_r;
    assign mem_oe_n = oe_n_r;
    assign mem_addr = pin_addr_r;
    assign mem_dq_out = dq_out_r;
    assign mem_dq_oe = dq_oe_r;

endmodule // nvsc_host_ctrl

// [hw/nvsc_pkg.sv]
package nvsc_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int TMR_W = 20;

    // ------------------------------------------------------------
    // Clock and device timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    // Slower grade figures cover the fast grade as well
    localparam int ACCESS_MIN_NS = 45;
    localparam int PWRUP_RECALL_MS = 40;
    localparam real STORE_TIME_COM_MS = 12.5;
    localparam real STORE_TIME_IND_MS = 15.0;
    localparam int SOFT_RECALL_US = 100;
    localparam int SOFT_SEQ_US = 70;

    // Least times round up, waits on device maxima are exact here
    localparam int STROBE_CYC = (ACCESS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PWRUP_CYC = PWRUP_RECALL_MS * 1000000 / CLK_PERIOD_NS;
    localparam int STORE_CYC_COM = int'(STORE_TIME_COM_MS * 1.0e6 / CLK_PERIOD_NS)
                                   + SOFT_SEQ_US * 1000 / CLK_PERIOD_NS;
    localparam int STORE_CYC_IND = int'(STORE_TIME_IND_MS * 1.0e6 / CLK_PERIOD_NS)
                                   + SOFT_SEQ_US * 1000 / CLK_PERIOD_NS;
    localparam int RECALL_CYC = (SOFT_RECALL_US + SOFT_SEQ_US) * 1000 / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Software command address sequence
    // ------------------------------------------------------------
    localparam int SEQ_LEN = 6;
    localparam logic [ADDR_W-1:0] SEQ_ADDR0 = 15'h0E38;
    localparam logic [ADDR_W-1:0] SEQ_ADDR1 = 15'h31C7;
    localparam logic [ADDR_W-1:0] SEQ_ADDR2 = 15'h03E0;
    localparam logic [ADDR_W-1:0] SEQ_ADDR3 = 15'h3C1F;
    localparam logic [ADDR_W-1:0] SEQ_ADDR4 = 15'h303F;
    localparam logic [ADDR_W-1:0] SEQ_STORE = 15'h0FC0;
    localparam logic [ADDR_W-1:0] SEQ_RECALL = 15'h0C63;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_READ = 2'h0,
        OP_WRITE = 2'h1,
        OP_STORE = 2'h2,
        OP_RECALL = 2'h3
    } nvsc_op_t;

    typedef enum logic [5:0] {
        ST_OFF = 6'b00_0001,
        ST_IDLE = 6'b00_0010,
        ST_SETUP = 6'b00_0100,
        ST_STROBE = 6'b00_1000,
        ST_HOLD = 6'b01_0000,
        ST_NVWAIT = 6'b10_0000
    } nvsc_state_t;

endpackage

// [hw/nvsc_wait_timer.sv]
`timescale 1ns/1ps
module nvsc_wait_timer #(
    parameter int W = 20
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Load side
    input wire logic start,
    input wire logic [W-1:0] load,
    // Status
    output logic expired
);

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic expired_r;

    // Load wins over counting; stops at zero
    assign cnt_nxt = start ? load : ((cnt_r != '0) ? cnt_r - 1'b1 : cnt_r);
    assign expired = expired_r;

    // Expired rises the edge the count reaches zero, so a load of N-1 spans N cycles
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            expired_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            expired_r <= (cnt_nxt == '0);
        end
    end

endmodule // nvsc_wait_timer

// [testbench/nvsc_host_ctrl_sva.sv]
`timescale 1ns/1ps
module nvsc_host_ctrl_sva
    import nvsc_pkg::*;
#(
    parameter int unsigned PWRUP_WAIT_CYC = 20,
    parameter int unsigned STORE_WAIT_CYC = 30
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // User side
    input wire logic vcc_ok,
    input wire logic cmd_valid,
    input wire nvsc_pkg::nvsc_op_t cmd_op,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    // Memory pins
    input wire logic mem_ce_n,
    input wire logic mem_we_n,
    input wire logic mem_oe_n,
    input wire logic [nvsc_pkg::ADDR_W-1:0] mem_addr,
    input wire logic mem_dq_oe
);
    // ------------------------------------------------------------
    // Pin protocol checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Request accepted on this edge
    wire taken = cmd_ready && cmd_valid && vcc_ok;

    a_read_we_high: assert property (!mem_oe_n |-> mem_we_n)
        else $error("output gate low with write strobe low");
    a_write_gate_off: assert property ($fell(mem_ce_n) && !mem_we_n |-> !$past(mem_we_n) && mem_oe_n)
        else $error("write strobe did not lead chip select");
    a_strobe_one: assert property ($fell(mem_ce_n) |=> $rose(mem_ce_n))
        else $error("chip select strobe not one cycle");
    a_write_addr: assert property (!mem_we_n && !$fell(mem_we_n) |-> $stable(mem_addr) && mem_dq_oe)
        else $error("address moved during write");
    // Supply drop may abort an access, so it also disables this one
    a_rw_answer: assert property (disable iff (!rst_n || !vcc_ok)
        taken && cmd_op inside {OP_READ, OP_WRITE} |-> ##4 rsp_valid && cmd_ready)
        else $error("read or write answer late");
    a_store_seq: assert property (taken && cmd_op == OP_STORE |=> (mem_addr == SEQ_ADDR0)[*3]
        ##1 (mem_addr == SEQ_ADDR1)[*3] ##1 (mem_addr == SEQ_ADDR2)[*3] ##1 (mem_addr == SEQ_ADDR3)[*3]
        ##1 (mem_addr == SEQ_ADDR4)[*3] ##1 (mem_addr == SEQ_STORE)[*3])
        else $error("store address sequence wrong");
    a_recall_seq: assert property (taken && cmd_op == OP_RECALL |=> (mem_addr == SEQ_ADDR0)[*3]
        ##1 (mem_addr == SEQ_ADDR1)[*3] ##1 (mem_addr == SEQ_ADDR2)[*3] ##1 (mem_addr == SEQ_ADDR3)[*3]
        ##1 (mem_addr == SEQ_ADDR4)[*3] ##1 (mem_addr == SEQ_RECALL)[*3])
        else $error("recall address sequence wrong");
    a_seq_quiet: assert property (taken && cmd_op inside {OP_STORE, OP_RECALL}
        |=> (mem_we_n && mem_oe_n)[*8])
        else $error("write strobe or gate active in sequence");
    a_low_supply: assert property (!vcc_ok |=> mem_ce_n && !cmd_ready)
        else $error("access while supply low");

    // Cycles since a software store was taken; too long to count with a repetition
    localparam int unsigned STORE_RSP_CYC = 3 * SEQ_LEN + STORE_WAIT_CYC + 1;
    int unsigned nv_cnt_r;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            nv_cnt_r <= 0;
        end else if (taken && cmd_op == OP_STORE) begin
            nv_cnt_r <= 1;
        end else if (nv_cnt_r != 0 && !rsp_valid && vcc_ok) begin
            nv_cnt_r <= nv_cnt_r + 1;
        end else begin
            nv_cnt_r <= 0;
        end
    end
    a_store_bound: assert property (nv_cnt_r != 0 |-> ((nv_cnt_r < STORE_RSP_CYC) ? !rsp_valid
        : (nv_cnt_r == STORE_RSP_CYC && rsp_valid)))
        else $error("store answer not at the expected cycle");
endmodule // nvsc_host_ctrl_sva

bind nvsc_host_ctrl nvsc_host_ctrl_sva #(.PWRUP_WAIT_CYC(PWRUP_WAIT_CYC), .STORE_WAIT_CYC(STORE_WAIT_CYC)) chk (
    .core_clk(core_clk), .rst_n(rst_n), .vcc_ok(vcc_ok), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .mem_ce_n(mem_ce_n), .mem_we_n(mem_we_n),
    .mem_oe_n(mem_oe_n), .mem_addr(mem_addr), .mem_dq_oe(mem_dq_oe));

// [testbench/nvsc_mem_model.sv]
`timescale 1ns/1ps
module nvsc_mem_model
    import nvsc_pkg::*;
#(
    parameter int STORE_NS = 1000,
    parameter int RECALL_NS = 100000,
    parameter int PWRUP_NS = 800
) (
    // Clock and supply
    input wire logic core_clk,
    input wire logic vcc_ok,
    // Memory pins
    input wire logic mem_ce_n,
    input wire logic mem_we_n,
    input wire logic mem_oe_n,
    input wire logic [nvsc_pkg::ADDR_W-1:0] mem_addr,
    input wire logic [nvsc_pkg::DATA_W-1:0] mem_dq_out,
    output logic [nvsc_pkg::DATA_W-1:0] mem_dq_in
);
    // ------------------------------------------------------------
    // Array, nonvolatile copy and state
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem [0:32767];
    logic [DATA_W-1:0] nv [0:32767];
    localparam logic [ADDR_W-1:0] SEQ_TAB [0:4] = '{SEQ_ADDR0, SEQ_ADDR1, SEQ_ADDR2, SEQ_ADDR3, SEQ_ADDR4};
    logic nv_busy = 1'b0;
    logic wr_flag = 1'b0;
    logic wr_first = 1'b0;
    logic [DATA_W-1:0] junk = 8'h5a;
    int idx = 0;

    // Whole-array copy in zero time, either way
    task automatic copy(input bit to_nv);
        for (int i = 0; i < 32768; i++) begin
            if (to_nv) nv[i] = mem[i];
            else mem[i] = nv[i];
        end
    endtask

    initial begin
        for (int i = 0; i < 32768; i++) begin
            mem[i] = 8'h00;
            nv[i] = 8'h00;
        end
    end

    // Floating bus: changes each cycle so a stale value never matches
    always @(posedge core_clk) junk <= junk + 8'h3b;
    assign mem_dq_in = (vcc_ok && !nv_busy && !mem_ce_n && !mem_oe_n && mem_we_n && !wr_first)
                       ? mem[mem_addr] : junk;

    // Automatic store only if the array was written
    always @(negedge vcc_ok) if (wr_flag) begin
        copy(1'b1);
        wr_flag = 1'b0;
    end

    // Power-up recall, array locked meanwhile
    always @(posedge vcc_ok) begin
        nv_busy = 1'b1;
        #PWRUP_NS;
        copy(1'b0);
        wr_flag = 1'b0;
        idx = 0;
        nv_busy = 1'b0;
    end

    // Accesses decoded at chip select fall
    always @(negedge mem_ce_n) begin
        wr_first = !mem_we_n;
        if (vcc_ok && !nv_busy) begin
            if (!mem_we_n) begin
                mem[mem_addr] = mem_dq_out;
                wr_flag = 1'b1;
                idx = 0;
            end else if (idx == 5 && mem_addr[12:0] == SEQ_STORE[12:0]) begin
                idx = 0;
                nv_busy = 1'b1;
                #STORE_NS;
                copy(1'b1);
                wr_flag = 1'b0;
                nv_busy = 1'b0;
            end else if (idx == 5 && mem_addr[12:0] == SEQ_RECALL[12:0]) begin
                idx = 0;
                nv_busy = 1'b1;
                #RECALL_NS;
                copy(1'b0);
                wr_flag = 1'b0;
                nv_busy = 1'b0;
            end else if (idx < 5 && mem_addr[12:0] == SEQ_TAB[idx][12:0]) idx++;
            else idx = (mem_addr[12:0] == SEQ_ADDR0[12:0]) ? 1 : 0;
        end
    end
endmodule // nvsc_mem_model

// [testbench/nvsc_host_ctrl_tb.sv]
`timescale 1ns/1ps
module nvsc_host_ctrl_tb;
    import nvsc_pkg::*;
    // ------------------------------------------------------------
    // Signals and bookkeeping
    // ------------------------------------------------------------
    logic core_clk, rst_n, vcc_ok, cmd_valid, cmd_ready, rsp_valid, busy;
    logic mem_ce_n, mem_we_n, mem_oe_n, mem_dq_oe;
    nvsc_op_t cmd_op;
    logic [ADDR_W-1:0] cmd_addr, mem_addr;
    logic [DATA_W-1:0] cmd_wdata, rsp_rdata, mem_dq_out, mem_dq_in;
    int miscompares = 0;
    int compares = 0;
    integer seed = 32'h5fc2;
    logic [8:0] exp_q[$];
    logic [8:0] exp_n;
    logic [ADDR_W-1:0] a_tab [0:7];
    logic [DATA_W-1:0] d_tab [0:7];

    nvsc_host_ctrl #(.PWRUP_WAIT_CYC(20), .STORE_WAIT_CYC(30)) uut (.core_clk(core_clk), .rst_n(rst_n),
        .vcc_ok(vcc_ok), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .busy(busy), .mem_ce_n(mem_ce_n),
        .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n), .mem_addr(mem_addr), .mem_dq_out(mem_dq_out),
        .mem_dq_oe(mem_dq_oe), .mem_dq_in(mem_dq_in));
    nvsc_mem_model mem_model (.core_clk(core_clk), .vcc_ok(vcc_ok), .mem_ce_n(mem_ce_n), .mem_we_n(mem_we_n),
        .mem_oe_n(mem_oe_n), .mem_addr(mem_addr), .mem_dq_out(mem_dq_out), .mem_dq_in(mem_dq_in));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task give_verdict;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task check_byte(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: read %h expected %h", $time, got, exp);
        end
    endtask

    task check_flag(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    // Bounded wait at falling edges; recall waits are the longest
    task wait_ready;
        int n;
        n = 0;
        @(negedge core_clk);
        while (cmd_ready !== 1'b1) begin
            @(negedge core_clk);
            n++;
            if (n > 5000) begin
                miscompares++;
                $display("mismatch at %0t: ready never came", $time);
                give_verdict;
            end
        end
    endtask

    // One command, held one cycle while ready is high
    task send(input nvsc_op_t op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
              input logic [DATA_W-1:0] e);
        wait_ready;
        exp_q.push_back({op == OP_READ, e});
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_addr = a;
        cmd_wdata = d;
        @(negedge core_clk);
        cmd_valid = 1'b0;
    endtask

    // Response watcher pairs each answer with the oldest note; falling edge keeps clear of launch edge
    always @(negedge core_clk) if (rsp_valid === 1'b1) begin
        check_flag(busy, 1'b0);
        if (exp_q.size() == 0) begin
            miscompares++;
            $display("mismatch at %0t: answer without request", $time);
        end else begin
            exp_n = exp_q.pop_front();
            if (exp_n[8]) check_byte(rsp_rdata, exp_n[7:0]);
        end
    end

    initial begin
        #2000000;
        miscompares++;
        $display("mismatch at %0t: watchdog expired", $time);
        give_verdict;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        vcc_ok = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = OP_READ;
        cmd_addr = ADDR_RST;
        cmd_wdata = DATA_RST;
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        vcc_ok = 1'b1;
        // Random writes back to back, then read back
        for (int i = 0; i < 8; i++) begin
            a_tab[i] = {i[2:0], 12'($random(seed))};
            d_tab[i] = 8'($random(seed));
            send(OP_WRITE, a_tab[i], d_tab[i], 8'h00);
        end
        for (int i = 0; i < 8; i++) send(OP_READ, a_tab[i], 8'h00, d_tab[i]);
        // Store, overwrite, recall brings the stored byte back
        send(OP_WRITE, a_tab[0], 8'h3c, 8'h00);
        send(OP_STORE, ADDR_RST, 8'h00, 8'h00);
        send(OP_WRITE, a_tab[0], 8'hc3, 8'h00);
        send(OP_READ, a_tab[0], 8'h00, 8'hc3);
        send(OP_RECALL, ADDR_RST, 8'h00, 8'h00);
        send(OP_READ, a_tab[0], 8'h00, 8'h3c);
        send(OP_READ, a_tab[1], 8'h00, d_tab[1]);
        // Supply loss after a write saves it, power-up recall restores it
        send(OP_WRITE, a_tab[1], ~d_tab[1], 8'h00);
        wait_ready;
        vcc_ok = 1'b0;
        repeat (5) @(negedge core_clk);
        vcc_ok = 1'b1;
        send(OP_READ, a_tab[1], 8'h00, ~d_tab[1]);
        send(OP_READ, a_tab[0], 8'h00, 8'h3c);
        wait_ready;
        repeat (4) @(negedge core_clk);
        if (exp_q.size() != 0) begin
            miscompares++;
            $display("mismatch at %0t: answers missing", $time);
        end
        give_verdict;
    end
endmodule // nvsc_host_ctrl_tb
